// >>> verification/dma_pipe_model.sv
// fetch and decode side: hands one instruction to the core per q1
`timescale 1ns/100ps
module dma_pipe_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] phase,
  input wire logic go,
  input wire dma_pkg::dma_pc_op_t op,
  output logic instr_valid,
  output dma_pkg::dma_pc_op_t pc_op
);
  // launch on the q4 edge so the word stands over q1; idle pc holds still
  always_ff @(posedge ref_clk) begin
    if (!reset && go && phase == 2'd3) begin
      instr_valid <= 1'b1;
      pc_op <= op;
    end else begin
      instr_valid <= 1'b0;
      pc_op <= dma_pkg::dma_pc_hold;
    end
  end
endmodule

// >>> verification/dma_properties.sv
// concurrent checks on the data memory addressing top ports
`timescale 1ns/100ps
module dma_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic first_word_prev,
  input wire dma_pkg::dma_pc_op_t pc_op,
  input wire logic [19:0] word_target,
  input wire logic [10:0] rel_offset,
  input wire logic [7:0] operand,
  input wire logic access_sel,
  input wire logic full_address_move,
  input wire logic [11:0] full_addr,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic data_wr,
  input wire logic status_update,
  input wire logic [20:0] pc,
  input wire logic [7:0] reg_rdata,
  input wire logic [11:0] data_addr,
  input wire logic cont_data_valid,
  input wire logic [11:0] cont_data,
  input wire logic cont_nop,
  input wire logic [1:0] phase
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // q1 edge; only a continuation word without a first word is kept from data memory
  wire q1 = phase == 2'd0;
  wire cw = q1 && instr_valid && instr_word[15:12] == 4'hf;
  wire da = q1 && instr_valid && instr_word[15:12] != 4'hf;
  wire [20:0] rel_b = {{9{rel_offset[10]}}, rel_offset, 1'b0};
  a_pc_even: assert property (pc[0] == 1'b0)
    else $error("pc odd");
  a_pc_step: assert property (q1 && pc_op == dma_pkg::dma_pc_seq |=> pc == $past(pc + 21'h2))
    else $error("pc step");
  a_pc_abs: assert property (q1 && pc_op == dma_pkg::dma_pc_abs |=> pc == {$past(word_target), 1'b0})
    else $error("pc absolute");
  a_pc_rel: assert property (q1 && pc_op == dma_pkg::dma_pc_rel |=> pc == $past(pc + 21'h2 + rel_b))
    else $error("pc relative");
  a_status_pulse: assert property (da |-> ##4 status_update == $past(data_wr, 4))
    else $error("status update pulse");
  a_bank_upper: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[7:4] == 4'h0)
    else $error("bank upper bits");
  a_access_map: assert property (da && !access_sel && !full_address_move |=>
    data_addr == $past({operand < 8'h60 ? 4'h0 : 4'hf, operand}))
    else $error("access map");
  a_full_move: assert property (da && full_address_move |=> data_addr == $past(full_addr))
    else $error("full move address");
  a_cont_kind: assert property (cw |=> cont_nop != $past(first_word_prev) &&
    cont_data_valid == $past(first_word_prev))
    else $error("continuation kind");
  a_cont_data: assert property (cw && first_word_prev |=> cont_data == $past(instr_word[11:0]))
    else $error("continuation data");
  a_phase_order: assert property (q1 |=> phase == 2'd1 ##1 phase == 2'd2 ##1 phase == 2'd3 ##1 q1)
    else $error("phase order");
endmodule
bind dma_top dma_chk i_chk (.*);

// >>> verification/dma_top_tb.sv
// self-checking bench for the data memory addressing top
`timescale 1ns/100ps
module dma_top_tb;
  logic ref_clk = 1'b0, reset = 1'b1, go = 1'b0, first_word_prev = 1'b0, access_sel = 1'b0;
  logic full_address_move = 1'b0, extended_set_enable = 1'b0, load_bank_literal = 1'b0;
  logic data_rd = 1'b0, data_wr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic instr_valid, cont_data_valid, cont_nop, status_update;
  logic [15:0] instr_word = 16'h0;
  logic [19:0] word_target = 20'h0;
  logic [10:0] rel_offset = 11'h0;
  logic [7:0] operand = 8'h0, bank_literal = 8'h0, data_wdata = 8'h0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata, data_rdata;
  logic [11:0] full_addr = 12'h0, data_addr, cont_data;
  logic [20:0] pc;
  logic [1:0] phase;
  dma_pkg::dma_pc_op_t op = dma_pkg::dma_pc_hold;
  dma_pkg::dma_pc_op_t pc_op;
  int mismatches = 0;
  int total_checks = 0;
  dma_top #(.BANKS(4)) i_dut (.*);
  dma_pipe_model i_pipe (.*);
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [20:0] s, input logic [20:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic wr_reg(input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= 8'h00;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic lit(input logic [7:0] b);
    @(posedge ref_clk);
    bank_literal <= b;
    load_bank_literal <= 1'b1;
    @(posedge ref_clk);
    load_bank_literal <= 1'b0;
  endtask
  // one instruction: m 1 reads, 2 writes; address at c1, read data at c3
  task automatic ins(input logic [15:0] w, input logic [7:0] o, input logic a,
    input logic [1:0] m, input logic [11:0] ea, input logic [7:0] ed);
    int n = 0;
    @(posedge ref_clk);
    instr_word <= w;
    operand <= o;
    access_sel <= a;
    data_rd <= m == 2'd1;
    data_wr <= m == 2'd2;
    data_wdata <= ed;
    go <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (instr_valid !== 1'b1 && n < 9);
    if (instr_valid !== 1'b1) begin
      mismatches++;
      summarize();
    end
    go <= 1'b0;
    @(negedge ref_clk);
    if (w[15:12] == 4'hf) begin
      chk("cont", {cont_nop, cont_data_valid, cont_data & {12{first_word_prev}}},
        {!first_word_prev, first_word_prev, w[11:0] & {12{first_word_prev}}});
    end else begin
      chk("data_addr", data_addr, ea);
    end
    repeat (2) @(negedge ref_clk);
    if (m == 2'd1) chk("data_rdata", data_rdata, ed);
    // hand back on a rising edge so callers drive inputs there
    @(posedge ref_clk);
  endtask
  task automatic t_pc;
    logic [20:0] p;
    p = pc;
    op <= dma_pkg::dma_pc_seq;
    ins(16'h0, 8'h0, 1'b0, 2'd0, 12'h000, 8'h0);
    chk("pc", pc, p + 21'h2);
    op <= dma_pkg::dma_pc_abs;
    word_target <= 20'h00003;
    ins(16'h0, 8'h0, 1'b0, 2'd0, 12'h000, 8'h0);
    chk("pc", pc, 21'h000006);
    op <= dma_pkg::dma_pc_rel;
    rel_offset <= 11'h7fe;
    ins(16'h0, 8'h0, 1'b0, 2'd0, 12'h000, 8'h0);
    chk("pc", pc, 21'h000004);
    op <= dma_pkg::dma_pc_hold;
  endtask
  task automatic t_cont;
    ins(16'hf456, 8'h0, 1'b0, 2'd0, 12'h000, 8'h0);
    first_word_prev <= 1'b1;
    ins(16'hf456, 8'h0, 1'b0, 2'd0, 12'h000, 8'h0);
    first_word_prev <= 1'b0;
  endtask
  task automatic t_mem;
    lit(8'h32);
    rd_reg(8'h00, 8'h02);
    wr_reg(8'hff);
    rd_reg(8'h00, 8'h0f);
    rd_reg(8'h01, 8'h00);
    wr_reg(8'h02);
    ins(16'h0, 8'h10, 1'b1, 2'd2, 12'h210, 8'ha5);
    ins(16'h0, 8'h10, 1'b1, 2'd1, 12'h210, 8'ha5);
    // bank 6 aliases bank 2 in storage, so a leaked write would show at 210
    lit(8'h06);
    ins(16'h0, 8'h10, 1'b1, 2'd2, 12'h610, 8'h5a);
    ins(16'h0, 8'h10, 1'b1, 2'd1, 12'h610, 8'h00);
    lit(8'h02);
    ins(16'h0, 8'h10, 1'b1, 2'd1, 12'h210, 8'ha5);
    ins(16'h0, 8'h5f, 1'b0, 2'd0, 12'h05f, 8'h0);
    ins(16'h0, 8'h60, 1'b0, 2'd1, 12'hf60, 8'h00);
    full_address_move <= 1'b1;
    full_addr <= 12'h123;
    ins(16'h0, 8'h60, 1'b1, 2'd0, 12'h123, 8'h0);
    full_address_move <= 1'b0;
    lit(8'h0f);
    ins(16'h0, 8'hf9, 1'b1, 2'd2, 12'hff9, 8'h40);
    @(negedge ref_clk);
    chk("pc_low", pc[7:0], 8'h40);
  endtask
  // five cycles of reset, then each scenario in turn
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_pc();
    t_cont();
    t_mem();
    summarize();
  end
endmodule

// >>> verilog/dma_addr_calc.sv
// combinational effective data address former
`timescale 1ns/100ps
`include "dma_cfg.svh"
module dma_addr_calc (
  input wire logic [3:0] bank,
  input wire logic [7:0] operand,
  input wire logic access_sel,
  input wire logic full_address_move,
  input wire logic [11:0] full_addr,
  input wire logic extended_set_enable,
  output logic [11:0] eff_addr
);
  // banked, access-bank or full-address forms
  always_comb begin
    if (full_address_move) begin
      eff_addr = full_addr;
    end else if (access_sel) begin
      eff_addr = {bank, operand};
    end else if (operand < `DMA_ACCESS_SPLIT) begin
      // extended_set_enable is not used anywhere; operand maps unchanged into bank 0 here
      eff_addr = {4'h0, operand};
    end else begin
      eff_addr = {`DMA_TOP_BANK, operand};
    end
  end
endmodule

// >>> verilog/dma_cfg.svh
// address-formation constants for the data memory addressing block
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
`define DMA_PC_W 21
`define DMA_PC_STEP 21'h000002
`define DMA_CONT_TAG 4'hf
`define DMA_DADDR_W 12
`define DMA_BANK_BYTES 256
`define DMA_BANKS_SMALL 4
`define DMA_BANKS_LARGE 8
`define DMA_ACCESS_SPLIT 8'h60
`define DMA_TOP_BANK 4'hf
`define DMA_PCL_OFFSET 8'hf9
`define DMA_BANK_MASK 8'h0f
`define DMA_RESET_PC 21'h000000
`define DMA_RESET_BANK 4'h0
`endif

// >>> verilog/dma_pc_calc.sv
// next program counter former
`timescale 1ns/100ps
`include "dma_cfg.svh"
module dma_pc_calc (
  input wire logic [20:0] pc,
  input wire dma_pkg::dma_pc_op_t op,
  input wire logic [19:0] word_target,
  input wire logic [10:0] rel_offset,
  output logic [20:0] pc_next
);
  logic [20:0] rel_bytes;
  // offsets count words, so shift left by one
  always_comb begin
    rel_bytes = {{9{rel_offset[10]}}, rel_offset, 1'b0};
    unique case (op)
      dma_pkg::dma_pc_seq: pc_next = pc + `DMA_PC_STEP;
      dma_pkg::dma_pc_abs: pc_next = {word_target, 1'b0};
      dma_pkg::dma_pc_rel: pc_next = pc + `DMA_PC_STEP + rel_bytes;
      dma_pkg::dma_pc_hold: pc_next = pc;
    endcase
    pc_next[0] = 1'b0;
  end
endmodule

// >>> verilog/dma_pkg.sv
// shared types for the data memory addressing block
package dma_pkg;
  typedef enum logic [1:0] {
    dma_pc_seq,
    dma_pc_abs,
    dma_pc_rel,
    dma_pc_hold
  } dma_pc_op_t;
  typedef enum logic [1:0] {
    dma_q1,
    dma_q2,
    dma_q3,
    dma_q4
  } dma_phase_t;
endpackage

// >>> verilog/dma_top.sv
// data memory addressing top: pc, bank pointer, data access sequencing
// Contract
// - program memory byte addressed, pc steps by two, bit zero reads zero
// - absolute jump target is a word address loaded into pc bits 20:1
// - relative offset counts words, byte displacement is twice the offset
// - continuation word recognised by top four bits all ones
// - continuation after first word supplies data, alone it is a no-op
// - data addresses are 12 bits, 16 banks of 256 bytes
// - implemented bank count is configurable, four or eight
// - reads of unimplemented locations return zero
// - bank pointer keeps low four bits, upper bits read zero
// - banked address is bank pointer over the 8-bit operand
// - load bank literal writes the bank pointer directly
// - writes to missing banks dropped, reads zero, status still updates
// - full address move uses 12-bit addresses and ignores bank pointer
// - access operands below 60h go to bank 0, others to bank 15
// - select bit one uses banked map, zero uses access map
// - access bank access needs one cycle and no bank update
// - banked write of f9h in bank 0fh alters the pc low byte
// - extended set enable selects an alternative access mapping (input unused here, access map is fixed)
// - operand read in phase two, destination write in phase four
`timescale 1ns/100ps
`include "dma_cfg.svh"
module dma_top #(
  parameter int BANKS = `DMA_BANKS_LARGE
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic first_word_prev,
  input wire dma_pkg::dma_pc_op_t pc_op,
  input wire logic [19:0] word_target,
  input wire logic [10:0] rel_offset,
  input wire logic [7:0] operand,
  input wire logic access_sel,
  input wire logic full_address_move,
  input wire logic [11:0] full_addr,
  input wire logic extended_set_enable,
  input wire logic load_bank_literal,
  input wire logic [7:0] bank_literal,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [20:0] pc,
  output logic [7:0] reg_rdata,
  output logic [11:0] data_addr,
  output logic [7:0] data_rdata,
  output logic cont_data_valid,
  output logic [11:0] cont_data,
  output logic cont_nop,
  output logic status_update,
  output logic [1:0] phase
);
  localparam int MEM_BYTES = BANKS * `DMA_BANK_BYTES;
  localparam logic [7:0] BANK_PTR_OFF = 8'h00;

  typedef struct packed {
    logic [20:0] pc;
    logic [3:0] bank;
    dma_pkg::dma_phase_t phase;
    logic [11:0] addr;
    logic rd_pend;
    logic wr_pend;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] reg_rdata;
    logic cont_valid;
    logic [11:0] cont_data;
    logic cont_nop;
    logic status_update;
  } dma_state_t;

  dma_state_t st;
  dma_state_t next_st;
  logic [20:0] pc_next;
  logic [11:0] eff_addr;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] mem_q;
  logic implemented;
  logic is_cont;

  dma_pc_calc u_pc (
    .pc(st.pc),
    .op(pc_op),
    .word_target(word_target),
    .rel_offset(rel_offset),
    .pc_next(pc_next)
  );

  dma_addr_calc u_addr (
    .bank(st.bank),
    .operand(operand),
    .access_sel(access_sel),
    .full_address_move(full_address_move),
    .full_addr(full_addr),
    .extended_set_enable(extended_set_enable),
    .eff_addr(eff_addr)
  );

  // banks above the configured count do not exist, except the top bank f, which is always flagged implemented
  assign implemented = (st.addr < 12'(MEM_BYTES)) ||
    (st.addr[11:8] == `DMA_TOP_BANK);
  assign is_cont = (instr_word[15:12] == `DMA_CONT_TAG);
  assign mem_q = mem[st.addr[$clog2(MEM_BYTES)-1:0]];

  // one step of the pipeline state
  always_comb begin
    next_st = st;
    next_st.status_update = 1'b0;
    next_st.cont_valid = 1'b0;
    next_st.cont_nop = 1'b0;
    next_st.phase = dma_pkg::dma_phase_t'(st.phase + 2'h1);
    if (st.phase == dma_pkg::dma_q1) begin
      next_st.pc = pc_next;
      if (instr_valid) begin
        next_st.addr = eff_addr;
        next_st.rd_pend = data_rd;
        next_st.wr_pend = data_wr;
        next_st.wdata = data_wdata;
        if (is_cont && first_word_prev) begin
          next_st.cont_valid = 1'b1;
          next_st.cont_data = instr_word[11:0];
        end else if (is_cont) begin
          next_st.cont_nop = 1'b1;
          next_st.rd_pend = 1'b0;
          next_st.wr_pend = 1'b0;
        end
      end
    end
    if (st.phase == dma_pkg::dma_q2 && st.rd_pend) begin
      // operand read happens in phase two
      // bank f storage is not held here, so only the bank pointer reads back there
      next_st.rdata = (implemented && st.addr[11:8] != `DMA_TOP_BANK) ? mem_q : 8'h00;
      if (st.addr == {`DMA_TOP_BANK, BANK_PTR_OFF}) begin
        next_st.rdata = {4'h0, st.bank};
      end
    end
    if (st.phase == dma_pkg::dma_q4 && st.wr_pend) begin
      next_st.status_update = 1'b1;
      next_st.wr_pend = 1'b0;
      if (st.addr == {`DMA_TOP_BANK, `DMA_PCL_OFFSET}) begin
        next_st.pc = {st.pc[20:8], st.wdata[7:1], 1'b0};
      end
    end
    if (load_bank_literal) begin
      next_st.bank = 4'(bank_literal & `DMA_BANK_MASK);
    end
    // software port for the bank pointer
    next_st.reg_rdata = 8'h00;
    if (reg_wr && reg_addr == BANK_PTR_OFF) begin
      next_st.bank = reg_wdata[3:0];
    end
    if (reg_rd && reg_addr == BANK_PTR_OFF) begin
      next_st.reg_rdata = {4'h0, st.bank};
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
      st.pc <= `DMA_RESET_PC;
      st.bank <= `DMA_RESET_BANK;
      st.phase <= dma_pkg::dma_q1;
    end else begin
      st <= next_st;
    end
  end

  // storage written in phase four, dropped outside implemented banks
  always_ff @(posedge ref_clk) begin
    if (st.phase == dma_pkg::dma_q4 && st.wr_pend && implemented &&
        st.addr[11:8] != `DMA_TOP_BANK) begin
      mem[st.addr[$clog2(MEM_BYTES)-1:0]] <= st.wdata;
    end
  end

  assign pc = st.pc;
  assign reg_rdata = st.reg_rdata;
  assign data_addr = st.addr;
  assign data_rdata = st.rdata;
  assign cont_data_valid = st.cont_valid;
  assign cont_data = st.cont_data;
  assign cont_nop = st.cont_nop;
  assign status_update = st.status_update;
  assign phase = st.phase;
endmodule
